// ---- src/vca_map.vh ----
`ifndef VCA_MAP_VH
`define VCA_MAP_VH
// Register word indexes; byte address is four times the index
`define VCA_REG_CTRL     4'h0
`define VCA_REG_CMD      4'h1
`define VCA_REG_ENTRY    4'h2
`define VCA_REG_STATUS   4'h3
`define VCA_REG_POS      4'h4
// Control word fields
`define VCA_CTRL_MODE    0
`define VCA_CTRL_CNT_A   1
`define VCA_CTRL_CNT_B   2
`define VCA_CTRL_FOURBIT 3
`define VCA_CTRL_CH_LO   4
`define VCA_CTRL_CH_HI   6
`define VCA_CTRL_RST     7'h01
// Command word fields
`define VCA_CMD_REC      0
`define VCA_CMD_PLAY     1
`define VCA_CMD_STOP     2
// Highest row for each memory size
`define VCA_ROW_256K     12'h0FF
`define VCA_ROW_512K     12'h1FF
`define VCA_ROW_1M       12'h3FF
`define VCA_ROW_2M       12'h7FF
`define VCA_ROW_3M       12'hBFF
`define VCA_ROW_4M       12'hFFF
// Index rows and first voice row
`define VCA_IDX_LAST     12'h007
`define VCA_VOICE_FIRST  12'h008
// Last column for each sample width
`define VCA_COL_3BIT     8'hA9
`define VCA_COL_4BIT     8'h7F
`endif

// ---- src/vca_alloc.v ----
// Notes on behaviour
// - Row address capped by memory size
// - Memory is 1K-bit rows, index and voice
// - Rows 000h-007h hold the channel index
// - Entry holds 12-bit start, 20-bit stop
// - Voice samples at row 008h upward, except flex chn after an unrecorded channel
// - 3-bit: column steps 00h to A9h
// - 4-bit: column steps 00h to 7Fh
// - Two selects plus pick give memory config
// - Shared pin is fourth select when both high
// - Mode bit low is direct, host only
// - Count selects give fixed 8/4/2 or flex
// - Fixed mode splits memory equally
// - Fixed recording starts at region head
// - Flex ch0 starts first voice row
// - Flex chn starts after previous stop
// - Direct and flex use three address bits
// - Fixed 4/2 mode ignores low address bits
// - Fixed capacity is size over count
// - Channel from pins or from host word
// - Playback ends at recorded stop address
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "vca_map.vh"
module vca_alloc (
   // Clock and reset
   input  wire        core_clk,
   input  wire        resetn,
   // Register port
   input  wire [3:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   // Configuration pins
   input  wire        mcu_mode_pin,
   input  wire        mem_cfg_sel_a,
   input  wire        mem_cfg_sel_b,
   input  wire        mem_size_pick_in,
   output wire        fourth_mem_select_out,
   output wire        fourth_mem_select_oe,
   input  wire        chan_count_sel_a,
   input  wire        chan_count_sel_b,
   input  wire        chan_addr_bit0,
   input  wire        chan_addr_bit1,
   input  wire        chan_addr_bit2,
   // Sample pair strobe from the codec
   input  wire        pair_tick,
   // Memory address outputs
   output reg  [11:0] mem_row_q,
   output reg  [7:0]  mem_col_q,
   output reg  [2:0]  mem_cs_n_q,
   // Index write to memory
   output reg         idx_wr_q,
   output reg  [11:0] idx_row_q,
   output reg  [31:0] idx_data_q,
   // Activity
   output reg         rec_q,
   output reg         play_q,
   output reg         done_q
);

   // ************************************************
   // Constants and state
   // ************************************************
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_REC  = 3'b010;
   localparam [2:0] ST_PLAY = 3'b100;

   reg  [2:0]  state_q;          // One-hot sequencer
   reg  [6:0]  ctrl_q;           // Control word
   reg  [11:0] start_tab [0:7];  // Head row per channel
   reg  [19:0] stop_tab  [0:7];  // Tail address per channel
   reg  [11:0] end_row_q;        // Last allowed row
   reg  [19:0] last_q;           // Last written pair
   reg  [2:0]  ch_q;             // Active channel
   reg         cs4_n_q;          // Fourth chip select
   reg         cs4_oe_q;         // Shared pin drives
   reg  [9:0]  s1_q;             // Pin sync stage one
   reg  [9:0]  s2_q;             // Pin sync stage two
   integer     i;

   // ************************************************
   // Helper functions
   // ************************************************
   // Memory size from the selects and the pick pin
   function [11:0] max_row;
      input a;
      input b;
      input pick;
      begin
         case ({b, a})
            2'b00: max_row = pick ? `VCA_ROW_512K
                                  : `VCA_ROW_256K;
            2'b01: max_row = `VCA_ROW_1M;
            2'b10: max_row = `VCA_ROW_2M;
            default: max_row = `VCA_ROW_4M;
         endcase
      end
   endfunction

   // Channel from address bits for a channel count
   function [2:0] chan_of;
      input [2:0] adr;
      input [1:0] shift;     // Three bits less this many
      begin
         case (shift)
            2'd1: chan_of = {1'b0, adr[2:1]};
            2'd2: chan_of = {2'b00, adr[2]};
            default: chan_of = adr;
         endcase
      end
   endfunction

   // ************************************************
   // Pin synchronisers
   // ************************************************
   // Pins are slow straps, two flops each
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         s1_q <= 10'h000;
         s2_q <= 10'h000;
      end else begin
         s1_q <= {mcu_mode_pin, mem_cfg_sel_a, mem_cfg_sel_b,
                  mem_size_pick_in, chan_count_sel_a,
                  chan_count_sel_b, chan_addr_bit2,
                  chan_addr_bit1, chan_addr_bit0, 1'b0};
         s2_q <= s1_q;
      end
   end

   wire       mcu_mode = s2_q[9];
   wire       sel_a    = s2_q[8];
   wire       sel_b    = s2_q[7];
   // The pick input is meaningless while it drives
   wire       pick     = s2_q[6] & ~(sel_a & sel_b);

   // ************************************************
   // Mode decode
   // ************************************************
   // Stand-alone forces the mode bit high
   wire       mode_bit = mcu_mode ? ctrl_q[`VCA_CTRL_MODE]
                                  : 1'b1;
   wire       cnt_a    = mcu_mode ? ctrl_q[`VCA_CTRL_CNT_A]
                                  : s2_q[5];
   wire       cnt_b    = mcu_mode ? ctrl_q[`VCA_CTRL_CNT_B]
                                  : s2_q[4];
   wire [2:0] ch_addr  = mcu_mode ?
                         ctrl_q[`VCA_CTRL_CH_HI:`VCA_CTRL_CH_LO]
                                  : s2_q[3:1];
   wire       direct   = ~mode_bit;
   wire       flex     = mode_bit & cnt_a & cnt_b;
   wire       fixed    = mode_bit & ~(cnt_a & cnt_b);
   // Channel count as a shift: 8, 4 or 2 channels
   wire [1:0] cnt_sh   = (~fixed)       ? 2'd0 :
                         (cnt_a)        ? 2'd1 :
                         (cnt_b)        ? 2'd2 : 2'd0;
   wire [2:0] chan     = chan_of(ch_addr, cnt_sh);

   // ************************************************
   // Address arithmetic
   // ************************************************
   wire [11:0] top_row = max_row(sel_a, sel_b, pick);
   wire [7:0]  col_max = ctrl_q[`VCA_CTRL_FOURBIT] ?
                         `VCA_COL_4BIT : `VCA_COL_3BIT;
   // Equal share of the whole memory per channel
   wire [12:0] size_rows = {1'b0, top_row} + 13'h0001;
   wire [12:0] region    = size_rows >> (2'd3 - cnt_sh);
   wire [12:0] reg_head  = region * {10'h000, chan};
   wire [12:0] reg_tail  = reg_head + region - 13'h0001;
   // Fixed and direct starts never fall in the index rows
   wire [11:0] raw_start = fixed ? reg_head[11:0] : start_tab[chan];
   wire [11:0] fix_start = (raw_start < `VCA_VOICE_FIRST)
                           ? `VCA_VOICE_FIRST : raw_start;
   wire [2:0]  prev_ch   = chan - 3'd1;
   wire [11:0] flex_start = (chan == 3'd0) ?
                           `VCA_VOICE_FIRST :
                           stop_tab[prev_ch][19:8]
                           + 12'h001;
   reg  [11:0] new_start;
   reg  [11:0] new_end;
   always @* begin
      // Pick the region for the selected mode
      if (fixed) begin
         new_start = fix_start;
         new_end   = reg_tail[11:0];
      end else if (flex) begin
         new_start = flex_start;
         new_end   = top_row;
      end else begin
         new_start = fix_start;
         new_end   = stop_tab[chan][19:8];
      end
   end

   // Row and column of the next pair
   wire        col_wrap = (mem_col_q == col_max);
   wire [11:0] row_next = col_wrap ? mem_row_q + 12'h001
                                   : mem_row_q;
   wire [7:0]  col_next = col_wrap ? 8'h00
                                   : mem_col_q + 8'h01;
   wire [19:0] here     = {mem_row_q, mem_col_q};

   // Selects from the row bits; they trail the row a cycle
   reg  [3:0]  cs_n_d;
   always @* begin
      cs_n_d = 4'hF;
      if (rec_q | play_q) begin
         case ({sel_b, sel_a})
            2'b10:   cs_n_d[{1'b0, mem_row_q[10]}] = 1'b0;
            2'b11:   cs_n_d[mem_row_q[11:10]]     = 1'b0;
            default: cs_n_d[0]                    = 1'b0;
         endcase
      end
   end

   // ************************************************
   // Register writes
   // ************************************************
   wire wr_ctrl  = reg_wr & (reg_addr == `VCA_REG_CTRL);
   wire wr_cmd   = reg_wr & (reg_addr == `VCA_REG_CMD);
   wire wr_entry = reg_wr & (reg_addr == `VCA_REG_ENTRY);
   wire go_rec   = wr_cmd & reg_wdata[`VCA_CMD_REC];
   wire go_play  = wr_cmd & reg_wdata[`VCA_CMD_PLAY]
                         & ~reg_wdata[`VCA_CMD_REC];
   wire stop_req = wr_cmd & reg_wdata[`VCA_CMD_STOP];

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         ctrl_q <= `VCA_CTRL_RST;
      else if (wr_ctrl)
         ctrl_q <= reg_wdata[6:0];
   end

   // ************************************************
   // Sequencer and index table
   // ************************************************
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q   <= ST_IDLE;
         mem_row_q <= `VCA_VOICE_FIRST;
         mem_col_q <= 8'h00;
         end_row_q <= `VCA_VOICE_FIRST;
         last_q    <= 20'h00000;
         ch_q      <= 3'd0;
         idx_wr_q  <= 1'b0;
         idx_row_q <= 12'h000;
         idx_data_q <= 32'h00000000;
         rec_q     <= 1'b0;
         play_q    <= 1'b0;
         done_q    <= 1'b0;
         for (i = 0; i < 8; i = i + 1) begin
            start_tab[i] <= `VCA_VOICE_FIRST;
            stop_tab[i]  <= 20'h00000;
         end
      end else begin
         idx_wr_q <= 1'b0;
         done_q   <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               // Host fills the index itself in direct mode
               if (wr_entry & direct & mcu_mode) begin
                  start_tab[chan] <= reg_wdata[31:20];
                  stop_tab[chan]  <= reg_wdata[19:0];
                  idx_wr_q   <= 1'b1;
                  idx_row_q  <= {9'h000, chan};
                  idx_data_q <= reg_wdata;
               end else if (go_rec | go_play) begin
                  ch_q      <= chan;
                  mem_row_q <= new_start;
                  mem_col_q <= 8'h00;
                  last_q    <= {new_start, 8'h00};
                  // Never step past the fitted memory
                  end_row_q <= (new_end > top_row) ?
                               top_row : new_end;
                  if (go_rec) begin
                     start_tab[chan] <= new_start;
                     state_q <= ST_REC;
                     rec_q   <= 1'b1;
                  end else begin
                     state_q <= ST_PLAY;
                     play_q  <= 1'b1;
                  end
               end
            end
            ST_REC: begin
               // Stop or full region closes the channel
               if (stop_req | (pair_tick & col_wrap &
                               (mem_row_q == end_row_q))) begin
                  state_q <= ST_IDLE;
                  rec_q   <= 1'b0;
                  done_q  <= 1'b1;
                  stop_tab[ch_q] <= stop_req ? last_q
                                             : here;
                  idx_wr_q   <= 1'b1;
                  idx_row_q  <= {9'h000, ch_q};
                  idx_data_q <= {start_tab[ch_q],
                                 stop_req ? last_q : here};
               end else if (pair_tick) begin
                  last_q    <= here;
                  mem_row_q <= row_next;
                  mem_col_q <= col_next;
               end
            end
            ST_PLAY: begin
               // Ends at the stored tail address
               if (stop_req | (pair_tick &
                   ((here == stop_tab[ch_q]) |
                    (col_wrap & (mem_row_q == end_row_q))))) begin
                  state_q <= ST_IDLE;
                  play_q  <= 1'b0;
                  done_q  <= 1'b1;
               end else if (pair_tick) begin
                  mem_row_q <= row_next;
                  mem_col_q <= col_next;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               rec_q   <= 1'b0;
               play_q  <= 1'b0;
            end
         endcase
      end
   end

   // ************************************************
   // Chip selects and shared pin
   // ************************************************
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         mem_cs_n_q <= 3'h7;
         cs4_n_q    <= 1'b1;
         cs4_oe_q   <= 1'b0;
      end else begin
         mem_cs_n_q <= cs_n_d[2:0];
         cs4_n_q    <= cs_n_d[3];
         cs4_oe_q   <= sel_a & sel_b;
      end
   end

   assign fourth_mem_select_out = cs4_n_q;
   assign fourth_mem_select_oe  = cs4_oe_q;

   // ************************************************
   // Register reads
   // ************************************************
   // Unmapped words read as zero
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         reg_rdata <= 32'h00000000;
      else if (reg_rd) begin
         case (reg_addr)
            `VCA_REG_CTRL:   reg_rdata <= {25'h0000000, ctrl_q};
            `VCA_REG_ENTRY:  reg_rdata <= {start_tab[chan],
                                           stop_tab[chan]};
            `VCA_REG_STATUS: reg_rdata <= {10'h000, top_row,
                                           1'b0, chan, flex,
                                           fixed, direct, mcu_mode,
                                           play_q, rec_q};
            `VCA_REG_POS:    reg_rdata <= {12'h000, here};
            default:         reg_rdata <= 32'h00000000;
         endcase
      end else
         reg_rdata <= 32'h00000000;
   end

endmodule // vca_alloc
`default_nettype wire

// ---- verif/vca_alloc_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
// ******
// Allocator checker
// ******
module vca_chk (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        resetn,
   // Pins and strobes
   input wire logic        mem_cfg_sel_a,
   input wire logic        mem_cfg_sel_b,
   input wire logic        pair_tick,
   // Watched outputs
   input wire logic        fourth_mem_select_out,
   input wire logic        fourth_mem_select_oe,
   input wire logic [11:0] mem_row_q,
   input wire logic [7:0]  mem_col_q,
   input wire logic [2:0]  mem_cs_n_q,
   input wire logic        idx_wr_q,
   input wire logic [11:0] idx_row_q,
   input wire logic        rec_q,
   input wire logic        play_q,
   input wire logic        done_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   wire logic both = mem_cfg_sel_a && mem_cfg_sel_b; // Four-chip strap

   a_voice_row:
      assert property (rec_q |-> mem_row_q >= 12'h008)
      else $error("recording below the voice rows");
   a_col_max:
      assert property (mem_col_q <= 8'hA9)
      else $error("column beyond last pair");
   // Below column 7Fh each pair moves the column by one
   a_col_step:
      assert property (rec_q && pair_tick && mem_col_q < 8'h7F
         |=> !rec_q || mem_col_q == $past(mem_col_q) + 8'h01)
      else $error("column did not advance");
   a_row_wrap:
      assert property (rec_q && pair_tick && mem_col_q == 8'hA9
         |=> !rec_q || (mem_col_q == 8'h00
         && mem_row_q == $past(mem_row_q) + 12'h001))
      else $error("row did not wrap");
   a_idx_row:
      assert property (idx_wr_q |-> idx_row_q <= 12'h007)
      else $error("index write outside index rows");
   a_end_done:
      assert property ($fell(rec_q) || $fell(play_q) |-> done_q)
      else $error("end without done pulse");
   a_stop_index:
      assert property ($fell(rec_q) |-> idx_wr_q)
      else $error("stop address not stored");
   // Selects are registered from the previous cycle's activity
   a_cs_one:
      assert property ($past(rec_q || play_q)
         |-> $countones({~fourth_mem_select_out, ~mem_cs_n_q}) == 1)
      else $error("chip selects not one-hot");
   // Strap needs two sync stages plus the output flop
   a_cs4_on:
      assert property (both [*4] |=> fourth_mem_select_oe)
      else $error("fourth select not driven");
   a_cs4_off:
      assert property (!both [*4] |=> !fourth_mem_select_oe)
      else $error("fourth select driven as input");
   c_rec: cover property ($rose(rec_q));
   c_done: cover property (done_q);
   c_wrap: cover property (rec_q && pair_tick && mem_col_q == 8'hA9);
   c_cs4: cover property (fourth_mem_select_oe);
endmodule // vca_chk
bind vca_alloc vca_chk i_chk (.core_clk, .resetn, .mem_cfg_sel_a,
   .mem_cfg_sel_b, .pair_tick, .fourth_mem_select_out,
   .fourth_mem_select_oe, .mem_row_q,
   .mem_col_q, .mem_cs_n_q, .idx_wr_q, .idx_row_q, .rec_q, .play_q,
   .done_q);
`default_nettype wire

// ---- verif/vca_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ******
// Serial memory model
// ******
module vca_mem (
   // Clock
   input wire logic        core_clk,
   // Voice pair writes
   input wire logic        rec_q,
   input wire logic        pair_tick,
   input wire logic [11:0] mem_row_q,
   // Index row writes
   input wire logic        idx_wr_q,
   input wire logic [11:0] idx_row_q,
   input wire logic [31:0] idx_data_q
);
   logic [31:0] idx_tab [0:7]; // One entry per channel
   int          pairs = 0;     // Pairs taken
   int          low_hits = 0;  // Pairs aimed at index rows
   // Store what the allocator hands over
   always @(posedge core_clk) begin
      if (idx_wr_q) begin
         idx_tab[idx_row_q[2:0]] <= idx_data_q;
      end
      if (rec_q && pair_tick) begin
         pairs <= pairs + 1;
         low_hits <= low_hits + int'(mem_row_q < 12'h008);
      end
   end
endmodule // vca_mem
`default_nettype wire

// ---- verif/vca_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
   // ******
   // Signals
   // ******
   logic core_clk = 1'h0, resetn = 1'h0;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, idx_data_q;
   logic reg_wr = 1'h0, reg_rd = 1'h0, pair_tick = 1'h0;
   logic mcu_mode_pin = 1'h1, mem_size_pick_in = 1'h0;
   logic mem_cfg_sel_a = 1'h1, mem_cfg_sel_b = 1'h0;
   logic chan_count_sel_a = 1'h0, chan_count_sel_b = 1'h0;
   logic chan_addr_bit0 = 1'h0, chan_addr_bit1 = 1'h0;
   logic chan_addr_bit2 = 1'h0, idx_wr_q, rec_q, play_q, done_q;
   logic fourth_mem_select_out, fourth_mem_select_oe;
   logic [11:0] mem_row_q, idx_row_q;
   logic [7:0] mem_col_q;
   logic [2:0] mem_cs_n_q;
   int mismatches = 0, total_checks = 0, recd = 0;
   always #25 core_clk = ~core_clk; // 20 MHz
   vca_alloc i_dut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .mcu_mode_pin, .mem_cfg_sel_a, .mem_cfg_sel_b,
      .mem_size_pick_in, .fourth_mem_select_out, .fourth_mem_select_oe,
      .chan_count_sel_a, .chan_count_sel_b, .chan_addr_bit0,
      .chan_addr_bit1, .chan_addr_bit2, .pair_tick, .mem_row_q,
      .mem_col_q, .mem_cs_n_q, .idx_wr_q, .idx_row_q, .idx_data_q,
      .rec_q, .play_q, .done_q);
   vca_mem i_mem (.core_clk, .rec_q, .pair_tick, .mem_row_q, .idx_wr_q,
      .idx_row_q, .idx_data_q);
   // ******
   // Tasks
   // ******
   task automatic chk(input string nm, input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge core_clk);
      reg_wr <= 1'h0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge core_clk);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge core_clk);
         pair_tick <= 1'h1;
         @(posedge core_clk);
         pair_tick <= 1'h0;
      end
      #1;
   endtask
   // Control word: channel, 4-bit flag, count code, mode bit
   function automatic logic [31:0] cw(input int ch, four, cnt);
      return 32'(ch * 16 + four * 8 + cnt * 2 + 1);
   endfunction
   // Region head on a 1M part; ch0 gives up the index rows
   function automatic logic [11:0] head(input int ch, cnt);
      int h = 1024 / cnt * ch;
      return 12'(h < 8 ? 8 : h);
   endfunction
   // Record n pairs from st, stop, check the stored entry
   task automatic run(input logic [31:0] c, input int n,
                      input logic [11:0] st);
      logic [19:0] sp;
      int l;
      l = c[3] ? 128 : 170;
      sp = {12'(st + (n - 1) / l), 8'((n - 1) % l)};
      wr(4'h0, c);
      wr(4'h1, 32'h1);
      chk("start", {19'h0, rec_q, mem_row_q}, {20'h1, st});
      tick(n);
      wr(4'h1, 32'h4);
      chk("index write", {31'h0, idx_wr_q}, 32'h1);
      chk("index entry", idx_data_q, {st, sp});
      recd += n;
      $display("test record %h done", c);
   endtask
   // Replay and count pairs until the stored end
   task automatic play(input logic [31:0] c, input int n);
      int k = 0;
      wr(4'h0, c);
      wr(4'h1, 32'h2);
      while (play_q === 1'h1 && k < 400) begin
         tick(1);
         k++;
      end
      chk("play pairs", k, n);
      $display("test play done");
   endtask
   // ******
   // Tests
   // ******
   initial begin
      logic [31:0] d;
      int n;
      logic [71:0] rows;
      void'($urandom(79));
      // Highest row per strap setting, lowest slice first
      rows = {12'h3FF, 12'h1FF, 12'hFFF, 12'h7FF, 12'h3FF, 12'h0FF};
      n = 1 + $urandom % 20;
      {chan_addr_bit2, chan_addr_bit1, chan_addr_bit0} <= 3'($urandom);
      repeat (20) @(posedge core_clk);
      resetn <= 1'h1;
      #1 chk("reset row", {20'h0, mem_row_q}, 32'h8);
      rd(4'h0, d);
      chk("ctrl reset", d, 32'h1);
      rd(4'hF, d);
      chk("unmapped", d, 32'h0);
      // Every strap setting in turn, ending on one 1M part
      for (int i = 0; i < 6; i++) begin
         @(posedge core_clk);
         mem_cfg_sel_a <= i[0];
         mem_cfg_sel_b <= i[1] && i < 4;
         mem_size_pick_in <= i == 4;
         repeat (5) @(posedge core_clk);
         #1 chk("cs4 oe", {31'h0, fourth_mem_select_oe}, 32'(i == 3));
         rd(4'h3, d);
         chk("max row", {20'h0, d[21:10]}, 32'(rows[i * 12 +: 12]));
      end
      $display("test memory config done");
      run(cw(3, 1, 0), n, head(3, 8));
      play(cw(3, 1, 0), n);
      run(cw(5, 1, 1), 3, head(2, 4));
      run(cw(3, 0, 2), 2, head(0, 2));
      run(cw(4, 0, 2), 2, head(1, 2));
      run(cw(0, 0, 0), 171, 12'h008);
      run(cw(0, 1, 0), 129, 12'h008);
      run(cw(0, 1, 3), 200, 12'h008);
      run(cw(1, 1, 3), n, 12'h00A);
      wr(4'h0, cw(5, 1, 0) - 1);
      wr(4'h2, 32'h0A00A005);
      rd(4'h2, d);
      chk("entry", d, 32'h0A00A005);
      run(cw(5, 1, 0) - 1, 4, 12'h0A0);
      chk("stored pairs", i_mem.pairs, recd);
      chk("index hits", i_mem.low_hits, 0);
      @(posedge core_clk) #1;
      chk("memory entry", i_mem.idx_tab[5], 32'h0A00A003);
      @(posedge core_clk);
      mcu_mode_pin <= 1'h0;
      chan_count_sel_a <= 1'h1;
      {chan_addr_bit2, chan_addr_bit1, chan_addr_bit0} <= 3'h6;
      repeat (5) @(posedge core_clk);
      rd(4'h3, d);
      chk("stand-alone", {26'h0, d[7:2]}, 32'h34);
      $display("test stand-alone done");
      results;
   end
   // Whole run is well under two thousand cycles; allow far more
   initial begin
      #4000000;
      mismatches++;
      results;
   end
endmodule // testbench
`default_nettype wire
